// ### panel_bus_host.sv
// host controller that drives the byte-to-word panel bus through its pins
// assumes apb commands on i_ref_clk and panel pins sampled synchronously
// one transfer at a time; a go while a transfer runs is refused with pslverr
`timescale 1ns/10ps
module panel_bus_host #(
    // cycles each pin step is held; must not exceed 2**STEP_W
    parameter int STEP_CYCLES = panel_bus_pkg::STEP_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [panel_bus_pkg::DATA_W-1:0] i_pwdata,
    output logic [panel_bus_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // shared byte pins
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    // conversion unit controls
    output logic o_buffer_direction_ctl,
    output logic o_buffer_output_enable_n,
    output logic o_low_byte_latch_enable,
    // panel controls
    output logic o_panel_select_n,
    output logic o_register_select,
    output logic o_write_strobe_n,
    output logic o_read_strobe_n,
    output logic o_panel_reset_n,
    output logic o_backlight_brightness_ctl,
    output logic [7:0] o_lamps,
    // touch controller
    input wire logic i_touch_press_irq_n,
    output logic o_touch_select_n
);
    import panel_bus_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        S_IDLE,
        S_SETUP, // buffer direction and enable
        S_LATCH_OPEN,
        S_LOW_BYTE,
        S_LATCH_CLOSE,
        S_HIGH_BYTE,
        S_SELECT,
        S_STROBE,
        S_SAMPLE_HIGH,
        S_SWAP, // enable high routes the low byte
        S_SAMPLE_LOW,
        S_UNSTROBE,
        S_DESELECT
    } step_t;

    typedef struct packed {
        // sequencer
        step_t step;
        logic [STEP_W-1:0] wait_cnt;
        logic is_read;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic done;
        // apb answer
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        // byte pins and panel controls
        logic [7:0] data;
        logic data_oe;
        logic dir;
        logic oe_n;
        logic le;
        logic cs_n;
        logic rs;
        logic wr_n;
        logic rd_n;
        // side lines
        logic panel_rst;
        logic panel_rst_n;
        logic pwm_mode;
        logic [PWM_W-1:0] duty;
        logic [PWM_W-1:0] pwm_cnt;
        logic bl;
        logic touch_cs_n;
        logic irq;
        logic [7:0] lamps;
    } state_t;

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic step_ok;
        logic apb_acc;
        logic idle;
        logic go_req;
        logic pwm_on;
        step_ok = 1'b0;
        apb_acc = 1'b0;
        idle = 1'b0;
        go_req = 1'b0;
        pwm_on = 1'b0;
        // everything but pready and pslverr holds unless a branch below moves it
        state_next = state_reg;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        apb_acc = i_psel && i_penable && !state_reg.pready;
        idle = (state_reg.step == S_IDLE);
        go_req = i_pwdata[CTRL_GO];
        // free-running step timer; a go restarts it so the first step is full length
        step_ok = (state_reg.wait_cnt == STEP_W'(STEP_CYCLES - 1));
        state_next.wait_cnt = step_ok ? '0 : state_reg.wait_cnt + 1'b1;

        ////////////////////////////////////////////////////////////////////////////////
        // apb answers one cycle after the access phase begins
        if (apb_acc) begin
            state_next.pready = 1'b1;
            state_next.prdata = '0;
            if (i_pwrite) begin
                unique case (i_paddr)
                    OFS_CTRL: begin
                        // rs only moves between transfers so it stands still across the strobe
                        if (idle) begin
                            state_next.rs = i_pwdata[CTRL_RS];
                        end
                        state_next.panel_rst = i_pwdata[CTRL_PANEL_RST];
                        state_next.pwm_mode = i_pwdata[CTRL_PWM_MODE];
                        if (go_req && idle) begin
                            state_next.is_read = i_pwdata[CTRL_READ];
                            state_next.done = 1'b0;
                            state_next.step = S_SETUP;
                            state_next.wait_cnt = '0;
                        end else if (go_req) begin
                            state_next.pslverr = 1'b1;
                        end
                    end
                    OFS_WDATA: begin
                        state_next.wdata = i_pwdata[15:0];
                    end
                    OFS_BACKLIGHT: begin
                        state_next.duty = i_pwdata[PWM_W-1:0];
                    end
                    OFS_TOUCH: begin
                        state_next.touch_cs_n = i_pwdata[0];
                    end
                    default: begin
                        state_next.pslverr = 1'b1;
                    end
                endcase
            end else begin
                unique case (i_paddr)
                    OFS_CTRL: begin
                        state_next.prdata = DATA_W'({state_reg.pwm_mode, state_reg.panel_rst,
                            state_reg.rs, state_reg.is_read, 1'b0});
                    end
                    OFS_WDATA: begin
                        state_next.prdata = DATA_W'(state_reg.wdata);
                    end
                    OFS_RDATA: begin
                        state_next.prdata = DATA_W'(state_reg.rdata);
                    end
                    OFS_STATUS: begin
                        state_next.prdata = DATA_W'({state_reg.irq, state_reg.done, !idle});
                    end
                    OFS_BACKLIGHT: begin
                        state_next.prdata = DATA_W'(state_reg.duty);
                    end
                    OFS_TOUCH: begin
                        state_next.prdata = DATA_W'(state_reg.touch_cs_n);
                    end
                    default: begin
                        state_next.pslverr = 1'b1;
                    end
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////////////////////
        // pin sequencer: each step lasts STEP_CYCLES cycles so the slow board parts settle
        if (step_ok) begin
            unique case (state_reg.step)
                S_IDLE: begin
                    // pins keep their last levels until the next go
                end
                S_SETUP: begin
                    // pins turn to outputs only for a write
                    state_next.data_oe = !state_reg.is_read;
                    state_next.dir = !state_reg.is_read;
                    state_next.oe_n = 1'b0;
                    state_next.step = state_reg.is_read ? S_SELECT : S_LATCH_OPEN;
                end
                S_LATCH_OPEN: begin
                    state_next.le = 1'b1;
                    state_next.step = S_LOW_BYTE;
                end
                S_LOW_BYTE: begin
                    state_next.data = state_reg.wdata[7:0];
                    state_next.step = S_LATCH_CLOSE;
                end
                S_LATCH_CLOSE: begin
                    // low byte is now held while the pins move on to the high byte
                    state_next.le = 1'b0;
                    state_next.step = S_HIGH_BYTE;
                end
                S_HIGH_BYTE: begin
                    state_next.data = state_reg.wdata[15:8];
                    state_next.step = S_SELECT;
                end
                S_SELECT: begin
                    state_next.cs_n = 1'b0;
                    state_next.step = S_STROBE;
                end
                S_STROBE: begin
                    if (state_reg.is_read) begin
                        state_next.rd_n = 1'b0;
                        state_next.step = S_SAMPLE_HIGH;
                    end else begin
                        state_next.wr_n = 1'b0;
                        state_next.step = S_UNSTROBE;
                    end
                end
                S_SAMPLE_HIGH: begin
                    // the board routes the high byte while enable is low
                    state_next.rdata[15:8] = i_data;
                    state_next.step = S_SWAP;
                end
                S_SWAP: begin
                    state_next.oe_n = 1'b1;
                    state_next.step = S_SAMPLE_LOW;
                end
                S_SAMPLE_LOW: begin
                    state_next.rdata[7:0] = i_data;
                    state_next.step = S_UNSTROBE;
                end
                S_UNSTROBE: begin
                    state_next.wr_n = 1'b1;
                    state_next.rd_n = 1'b1;
                    state_next.step = S_DESELECT;
                end
                S_DESELECT: begin
                    // enable back high so the buffer lets go of the panel side
                    state_next.cs_n = 1'b1;
                    state_next.oe_n = 1'b1;
                    state_next.done = 1'b1;
                    state_next.step = S_IDLE;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////////
        // lamps follow whatever is on the pins, driven or read
        state_next.lamps = state_reg.data_oe ? state_reg.data : i_data;
        state_next.irq = !i_touch_press_irq_n;
        // panel reset is low while the host is in reset or software asks for it
        state_next.panel_rst_n = !state_reg.panel_rst;
        // backlight: plain on/off from duty bit 0, or pwm against a free counter
        // the counter wraps every 2**PWM_W cycles, so duty counts the on cycles of a period
        state_next.pwm_cnt = state_reg.pwm_cnt + 1'b1;
        pwm_on = (state_reg.pwm_cnt < state_reg.duty);
        state_next.bl = state_reg.pwm_mode ? pwm_on : state_reg.duty[0];
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '{
                step: S_IDLE,
                cs_n: 1'b1,
                wr_n: 1'b1,
                rd_n: 1'b1,
                oe_n: 1'b1,
                touch_cs_n: 1'b1,
                default: '0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // every output is a plain copy of a flop, no gates after the register
    // apb answer
    assign o_prdata = state_reg.prdata;
    assign o_pready = state_reg.pready;
    assign o_pslverr = state_reg.pslverr;
    // pins
    assign o_data = state_reg.data;
    assign o_data_oe = state_reg.data_oe;
    assign o_buffer_direction_ctl = state_reg.dir;
    assign o_buffer_output_enable_n = state_reg.oe_n;
    assign o_low_byte_latch_enable = state_reg.le;
    assign o_panel_select_n = state_reg.cs_n;
    assign o_register_select = state_reg.rs;
    assign o_write_strobe_n = state_reg.wr_n;
    assign o_read_strobe_n = state_reg.rd_n;
    // side lines
    assign o_panel_reset_n = state_reg.panel_rst_n;
    assign o_backlight_brightness_ctl = state_reg.bl;
    assign o_lamps = state_reg.lamps;
    assign o_touch_select_n = state_reg.touch_cs_n;
endmodule

// ### panel_bus_pkg.sv
// constants for the byte-to-word panel bus host controller
// assumes an apb master for commands and the conversion board on the far side of the pins
// Notes on behaviour
// - eight shared port pins carry one byte
// - three conversion lines: direction, enable, latch
// - write: pins out, direction 1, enable 0
// - latch low byte, close latch, then high
// - select, set rs, pulse write, deselect; host sets rs with the go, before select
// - read: pins in, direction 0, enable 0
// - strobe read, sample high, enable 1, low
// - select and strobes active low beside data
// - touch on spi, own select, irq low
// - backlight on/off or pwm brightness
package panel_bus_pkg;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WDATA = 8'h04;
    localparam logic [7:0] OFS_RDATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_BACKLIGHT = 8'h10;
    localparam logic [7:0] OFS_TOUCH = 8'h14;
    // ctrl register fields; writing ctrl with go set while idle starts a transfer
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_RS = 2;
    localparam int CTRL_PANEL_RST = 3;
    localparam int CTRL_PWM_MODE = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_IRQ = 2;
    // each step of the pin sequence is held this long
    localparam int STEP_NS = 20;
    localparam int CLK_MHZ = 200;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int STEP_W = 4;
    localparam int PWM_W = 8;
endpackage

// ### panel_bus_props.sv
// checker for the panel bus host pin sequence and apb answer
// assumes it is bound to panel_bus_host
`timescale 1ns/10ps
module panel_bus_props (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic [7:0] i_data,
    input wire logic [7:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_buffer_direction_ctl,
    input wire logic o_buffer_output_enable_n,
    input wire logic o_low_byte_latch_enable,
    input wire logic o_panel_select_n,
    input wire logic o_register_select,
    input wire logic o_write_strobe_n,
    input wire logic o_read_strobe_n,
    input wire logic [7:0] o_lamps
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_pready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late pready");
    a_write_setup: assert property ($fell(o_write_strobe_n) |-> !o_panel_select_n && o_buffer_direction_ctl &&
        !o_buffer_output_enable_n && !o_low_byte_latch_enable && o_data_oe) else $error("bad write setup");
    a_read_setup: assert property ($fell(o_read_strobe_n) |-> !o_panel_select_n && !o_buffer_direction_ctl &&
        !o_buffer_output_enable_n && !o_data_oe) else $error("bad read setup");
    a_read_end: assert property ($rose(o_read_strobe_n) |-> !o_panel_select_n && o_buffer_output_enable_n)
        else $error("bad read end");
    a_strobe_selected: assert property ((!o_write_strobe_n || !o_read_strobe_n) |-> !o_panel_select_n)
        else $error("strobe unselected");
    a_rs_held: assert property (!o_panel_select_n && !$past(o_panel_select_n) |-> $stable(o_register_select))
        else $error("rs moved");
    a_latch_early: assert property (o_low_byte_latch_enable |-> o_panel_select_n && o_data_oe &&
        o_buffer_direction_ctl) else $error("latch misplaced");
    a_lamps_mirror: assert property ($past(i_rst_n) |-> o_lamps == ($past(o_data_oe) ? $past(o_data) :
        $past(i_data))) else $error("lamps wrong");
endmodule
bind panel_bus_host panel_bus_props u_props (.i_ref_clk, .i_rst_n, .i_psel, .i_penable, .o_pready, .i_data,
    .o_data, .o_data_oe, .o_buffer_direction_ctl, .o_buffer_output_enable_n, .o_low_byte_latch_enable,
    .o_panel_select_n, .o_register_select, .o_write_strobe_n, .o_read_strobe_n, .o_lamps);

// ### panel_board_model.sv
// conversion board and panel: low-byte latch, high-byte buffer, one panel word register
// assumes the host pins split as in panel_bus_host; the clock only paces the idle pattern
`timescale 1ns/10ps
module panel_board_model (
    input wire logic i_clk,
    input wire logic [7:0] i_host_byte,
    input wire logic i_host_oe,
    input wire logic i_dir,
    input wire logic i_oe_n,
    input wire logic i_le,
    input wire logic i_cs_n,
    input wire logic i_rs,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic [15:0] i_rd_word,
    output logic [7:0] o_pins,
    output logic [15:0] o_word,
    output logic o_rs,
    output logic [7:0] o_n_wr
);
    logic [7:0] lat = 8'h00;
    logic [7:0] pat = 8'h5A;
    initial o_n_wr = 8'h00;
    // undriven pins toggle so a stale byte is never mistaken for data
    always @(posedge i_clk) pat <= ~pat;
    always_latch if (i_le && i_host_oe) lat = i_host_byte;
    always @(posedge i_wr_n) if (!i_cs_n) begin
        o_word <= {i_host_byte, lat};
        o_rs <= i_rs;
        o_n_wr <= o_n_wr + 8'h01;
    end
    assign o_pins = i_host_oe ? i_host_byte : (!i_dir && !i_cs_n && !i_rd_n) ?
        (i_oe_n ? i_rd_word[7:0] : i_rd_word[15:8]) : pat;
endmodule

// ### tb_top.sv
// self-checking bench for panel_bus_host with the board model on its pins
// assumes the register map of panel_bus_pkg and a 200 MHz clock
`timescale 1ns/10ps
module tb_top;
    import panel_bus_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_n = 1'b1;
    logic [7:0] paddr = 8'h00, hd, pins, lamps, n_wr, duty_pick;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, err, hoe, dir, oen, le, csn, rs, wrn, rdn, prst_n, bl, tsel_n, rs_seen, wrs;
    logic [15:0] rd_word = 16'h0, word, w;
    int n_fail = 0, checks_done = 0, cyc = 0, n_on = 0;
    always #2.5 clk = ~clk;
    panel_bus_host u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_data(pins), .o_data(hd), .o_data_oe(hoe), .o_buffer_direction_ctl(dir),
        .o_buffer_output_enable_n(oen), .o_low_byte_latch_enable(le), .o_panel_select_n(csn),
        .o_register_select(rs), .o_write_strobe_n(wrn), .o_read_strobe_n(rdn), .o_panel_reset_n(prst_n),
        .o_backlight_brightness_ctl(bl), .o_lamps(lamps), .i_touch_press_irq_n(irq_n), .o_touch_select_n(tsel_n));
    panel_board_model u_board (.i_clk(clk), .i_host_byte(hd), .i_host_oe(hoe), .i_dir(dir), .i_oe_n(oen),
        .i_le(le), .i_cs_n(csn), .i_rs(rs), .i_wr_n(wrn), .i_rd_n(rdn), .i_rd_word(rd_word), .o_pins(pins),
        .o_word(word), .o_rs(rs_seen), .o_n_wr(n_wr));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input logic rd, input logic r);
        apb(1'b1, OFS_CTRL, (32'(r) << CTRL_RS) | (32'(rd) << CTRL_READ) | 32'h1);
        // a transfer takes many steps, so polling starts a little later
        repeat (8) @(posedge clk);
        do apb(1'b0, OFS_STATUS, 32'h0); while (rv[STAT_BUSY] !== 1'b0);
        chk(32'(rv[STAT_DONE]), 32'h1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h8CB3));
        repeat (8) @(posedge clk);
        chk(32'({csn, wrn, rdn, oen, prst_n, tsel_n}), 32'h3D);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(prst_n), 32'h1);
        for (int i = 0; i < 6; i++) begin
            w = (i < 2) ? (i ? 16'h00FF : 16'hFF00) : 16'($urandom);
            wrs = 1'($urandom);
            apb(1'b1, OFS_WDATA, 32'(w));
            xfer(1'b0, wrs);
            chk(32'(word), 32'(w));
            chk(32'(rs_seen), 32'(wrs));
        end
        $display("test write done");
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 16'h00FF : 16'($urandom);
            rd_word <= w;
            xfer(1'b1, 1'(i));
            apb(1'b0, OFS_RDATA, 32'h0);
            chk(32'(rv[15:0]), 32'(w));
        end
        chk(32'(n_wr), 32'h6);
        $display("test read done");
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h1);
        chk(32'(err), 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(err), 32'h1);
        $display("test refusal done");
        irq_n <= 1'b0;
        apb(1'b1, OFS_TOUCH, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h8);
        apb(1'b1, OFS_BACKLIGHT, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rv, 32'h8);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rv[STAT_IRQ]), 32'h1);
        chk(32'({tsel_n, prst_n, bl}), 32'h1);
        $display("test side lines done");
        duty_pick = 8'($urandom);
        apb(1'b1, OFS_BACKLIGHT, 32'(duty_pick));
        apb(1'b1, OFS_CTRL, 32'h1 << CTRL_PWM_MODE);
        @(posedge clk);
        n_on = 0;
        for (int k = 0; k < (1 << PWM_W); k++) begin
            @(posedge clk);
            n_on += (bl === 1'b1) ? 1 : 0;
        end
        chk(32'(n_on), 32'(duty_pick));
        $display("test pwm done");
        give_verdict();
    end
endmodule
